// ### src/amcr_regs.sv
`timescale 1ns/1ps
module amcr_regs #(
    parameter int ATTACK_BASE  = amcr_pkg::ATTACK_BASE_CYCLES,
    parameter int RELEASE_BASE = amcr_pkg::RELEASE_BASE_CYCLES
) (
    // Clock and reset
    input  wire logic               CLK,
    input  wire logic               ARST_N,
    // Host register access: one write strobe, combinational read
    input  wire amcr_pkg::amcr_wr_t WR,
    input  wire logic [7:0]         RD_ADDR,
    output logic [7:0]              RD_DATA,
    // Fault levels from the power stage, on this clock
    input  wire logic               OC_FAULT,
    input  wire logic               OT_FAULT,
    // Mode settings
    output logic [1:0]              SLEW_SELECT,
    output logic                    OVERCURRENT_AUTO_RESUME,
    output logic                    OVERTEMP_AUTO_RESUME,
    output logic                    RIGHT_TO_BOTH_MIX,
    output logic                    LEFT_TO_BOTH_MIX,
    // Level control setup, lock, fault latches and step pulses
    output amcr_pkg::amcr_setup_t   SETUP,
    output logic                    GAIN_WRITE_LOCK,
    output logic                    OC_LATCHED,
    output logic                    OT_LATCHED,
    output logic                    ATTACK_STEP,
    output logic                    RELEASE_STEP,
    output logic signed [7:0]       GAIN_STEP_HALF_DB
);

    typedef struct packed {
        // Register images, fixed-zero bits already masked
        logic [7:0]                          mode;
        logic [7:0]                          timing;
        logic [7:0]                          setup;
        // Fault latches, used only with autorecovery off
        logic                                oc_latched;
        logic                                ot_latched;
        // Step timers count down to zero, then reload; the width must hold
        // the longest period, the release base shifted by seven
        logic [amcr_pkg::STEP_CNT_W-1:0]     attack_cnt;
        logic [amcr_pkg::STEP_CNT_W-1:0]     release_cnt;
        // One-cycle pulses at the start of each step
        logic                                attack_step;
        logic                                release_step;
    } amcr_state_t;

    amcr_state_t state;
    amcr_state_t next_state;

    // Period of one step: base shifted left by the code, latched at step start
    function automatic logic [amcr_pkg::STEP_CNT_W-1:0] step_period(
        input int         base,
        input logic [2:0] code
    );
        logic [amcr_pkg::STEP_CNT_W-1:0] b;
        b = amcr_pkg::STEP_CNT_W'(base);
        return b << code;
    endfunction

    // A write request aimed at one register offset
    function automatic logic addr_hit(
        input amcr_pkg::amcr_wr_t req,
        input logic [7:0]         offset
    );
        return req.wr && (req.addr == offset);
    endfunction

    // Masked register write: only writable bits take the new data, so
    // fixed-zero bits stay zero however the host fills them.
    function automatic logic [7:0] write_reg(
        input logic [7:0] current,
        input logic       hit,
        input logic [7:0] data,
        input logic [7:0] mask
    );
        logic [7:0] result;
        result = current;
        if (hit)
        begin
            result = data & mask;
        end
        return result;
    endfunction

    // Fault latch: a fault with autorecovery off sets it and an error
    // clear drops it; the set wins so a fault still present is kept.
    function automatic logic latch_next(
        input logic latched,
        input logic fault,
        input logic auto_resume,
        input logic clear
    );
        logic result;
        result = latched;
        if (clear)
        begin
            result = 1'b0;
        end
        if (fault && !auto_resume)
        begin
            result = 1'b1;
        end
        return result;
    endfunction

    // A step starts on the cycle a running timer sits at zero
    function automatic logic step_fires(
        input logic [amcr_pkg::STEP_CNT_W-1:0] count
    );
        return count == '0;
    endfunction

    // Step counter: reload at zero with the period of the code read
    // now, else count down; a new code thus waits for the next step.
    function automatic logic [amcr_pkg::STEP_CNT_W-1:0] count_next(
        input logic [amcr_pkg::STEP_CNT_W-1:0] count,
        input int                              base,
        input logic [2:0]                      code
    );
        logic [amcr_pkg::STEP_CNT_W-1:0] result;
        if (step_fires(count))
        begin
            result = step_period(base, code) - 1'b1;
        end
        else
        begin
            result = count - 1'b1;
        end
        return result;
    endfunction

    // Read mux; offsets outside this slice read zero
    function automatic logic [7:0] read_reg(
        input amcr_state_t regs,
        input logic [7:0]  addr
    );
        logic [7:0] result;
        unique case (addr)
            amcr_pkg::MODE_CONTROL_ADDR:
            begin
                result = regs.mode;
            end
            amcr_pkg::LEVEL_CONTROL_TIMING_ADDR:
            begin
                result = regs.timing;
            end
            amcr_pkg::LEVEL_CONTROL_SETUP_ADDR:
            begin
                result = regs.setup;
            end
            default:
            begin
                result = 8'h00;
            end
        endcase
        return result;
    endfunction

    logic       wr_mode;
    logic       wr_timing;
    logic       wr_setup;
    logic       wr_clear;
    logic       lc_on;
    logic [2:0] attack_code;
    logic [2:0] release_code;

    // One strobe cycle is one write; the register changes on that edge
    assign wr_mode      = addr_hit(WR, amcr_pkg::MODE_CONTROL_ADDR);
    assign wr_timing    = addr_hit(WR, amcr_pkg::LEVEL_CONTROL_TIMING_ADDR);
    assign wr_setup     = addr_hit(WR, amcr_pkg::LEVEL_CONTROL_SETUP_ADDR);
    assign wr_clear     = addr_hit(WR, amcr_pkg::ERROR_CLEAR_ADDR);
    assign lc_on        = state.setup[amcr_pkg::LC_ON_BIT];
    assign attack_code  = state.timing[amcr_pkg::ATTACK_LSB +: 3];
    assign release_code = state.timing[amcr_pkg::RELEASE_LSB +: 3];

    always_comb
    begin
        next_state              = state;
        next_state.attack_step  = 1'b0;
        next_state.release_step = 1'b0;

        // Mode and timing writes drop bits 7:6
        next_state.mode   = write_reg(state.mode, wr_mode, WR.data,
            amcr_pkg::MODE_CONTROL_MASK);
        next_state.timing = write_reg(state.timing, wr_timing, WR.data,
            amcr_pkg::LEVEL_CONTROL_TIMING_MASK);
        // Every bit of the setup register is writable
        next_state.setup  = write_reg(state.setup, wr_setup, WR.data,
            8'hff);

        // Both latches share the one clear strobe
        next_state.oc_latched = latch_next(state.oc_latched, OC_FAULT,
            state.mode[amcr_pkg::OC_RESUME], wr_clear);
        next_state.ot_latched = latch_next(state.ot_latched, OT_FAULT,
            state.mode[amcr_pkg::OT_RESUME], wr_clear);

        // Step timers run only while the controller is enabled; holding
        // them at zero makes the first step start right after enable.
        if (!lc_on)
        begin
            next_state.attack_cnt = '0;
        end
        else
        begin
            next_state.attack_cnt  = count_next(state.attack_cnt,
                ATTACK_BASE, attack_code);
            next_state.attack_step = step_fires(state.attack_cnt);
        end

        if (!lc_on)
        begin
            next_state.release_cnt = '0;
        end
        else
        begin
            next_state.release_cnt  = count_next(state.release_cnt,
                RELEASE_BASE, release_code);
            next_state.release_step = step_fires(state.release_cnt);
        end
    end

    // Reset loads the power-on defaults field by field
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state.mode         <= amcr_pkg::MODE_CONTROL_RESET;
            state.timing       <= amcr_pkg::LEVEL_CONTROL_TIMING_RESET;
            state.setup        <= amcr_pkg::LEVEL_CONTROL_SETUP_RESET;
            state.oc_latched   <= 1'b0;
            state.ot_latched   <= 1'b0;
            state.attack_cnt   <= '0;
            state.release_cnt  <= '0;
            state.attack_step  <= 1'b0;
            state.release_step <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Combinational read, so a write shows on the very next cycle
    always_comb
    begin
        RD_DATA = read_reg(state, RD_ADDR);
    end

    // Mode register fields drive the amplifier settings directly
    assign SLEW_SELECT             = state.mode[amcr_pkg::SLEW_LSB +: 2];
    assign OVERCURRENT_AUTO_RESUME = state.mode[amcr_pkg::OC_RESUME];
    assign OVERTEMP_AUTO_RESUME    = state.mode[amcr_pkg::OT_RESUME];
    assign RIGHT_TO_BOTH_MIX       = state.mode[amcr_pkg::RIGHT_MIX];
    assign LEFT_TO_BOTH_MIX        = state.mode[amcr_pkg::LEFT_MIX];

    // Level control setup, unpacked field by field
    assign SETUP.level_control_on       = lc_on;
    assign SETUP.curve_select           = state.setup[amcr_pkg::CURVE_LSB +: 2];
    assign SETUP.threshold_basis_select = state.setup[amcr_pkg::BASIS_BIT];
    assign SETUP.threshold_level_select = state.setup[amcr_pkg::LEVEL_LSB +: 4];

    // The gain registers outside this slice must refuse writes while
    // this lock is high, so the controller alone moves the gain.
    assign GAIN_WRITE_LOCK         = lc_on;

    assign OC_LATCHED              = state.oc_latched;
    assign OT_LATCHED              = state.ot_latched;
    assign ATTACK_STEP             = state.attack_step;
    assign RELEASE_STEP            = state.release_step;

    // One gain step is one code unit of half a dB
    assign GAIN_STEP_HALF_DB       = 8'sh01;

endmodule // amcr_regs

// ### src/amcr_pkg.sv
package amcr_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] MODE_CONTROL_ADDR         = 8'h02;
    localparam logic [7:0] LEVEL_CONTROL_TIMING_ADDR = 8'h03;
    localparam logic [7:0] LEVEL_CONTROL_SETUP_ADDR  = 8'h04;
    localparam logic [7:0] ERROR_CLEAR_ADDR          = 8'h07;

    // Reset values
    localparam logic [7:0] MODE_CONTROL_RESET         = 8'h0c;
    localparam logic [7:0] LEVEL_CONTROL_TIMING_RESET = 8'h2b;
    localparam logic [7:0] LEVEL_CONTROL_SETUP_RESET  = 8'h5b;

    // Writable bit masks; cleared bits are fixed zero
    localparam logic [7:0] MODE_CONTROL_MASK         = 8'h3f;
    localparam logic [7:0] LEVEL_CONTROL_TIMING_MASK = 8'h3f;

    // Field positions
    localparam int SLEW_LSB     = 4;
    localparam int OC_RESUME    = 3;
    localparam int OT_RESUME    = 2;
    localparam int RIGHT_MIX    = 1;
    localparam int LEFT_MIX     = 0;
    localparam int RELEASE_LSB  = 3;
    localparam int ATTACK_LSB   = 0;
    localparam int LC_ON_BIT    = 7;
    localparam int CURVE_LSB    = 5;
    localparam int BASIS_BIT    = 4;
    localparam int LEVEL_LSB    = 0;

    // Step timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int ATTACK_BASE_US = 32;
    localparam int RELEASE_BASE_MS = 4;
    localparam int ATTACK_BASE_CYCLES  = CLK_HZ / 1_000_000 * ATTACK_BASE_US;
    localparam int RELEASE_BASE_CYCLES = CLK_HZ / 1_000 * RELEASE_BASE_MS;
    localparam int STEP_CNT_W = 32;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } amcr_wr_t;

    typedef struct packed {
        logic       level_control_on;
        logic [1:0] curve_select;
        logic       threshold_basis_select;
        logic [3:0] threshold_level_select;
    } amcr_setup_t;

endpackage

// ### tb/amcr_regs_properties.sv
`timescale 1ns/1ps
module amcr_regs_properties #(
    parameter int ATTACK_BASE  = 4,
    parameter int RELEASE_BASE = 8
) (
    input wire logic                  CLK,
    input wire logic                  ARST_N,
    input wire amcr_pkg::amcr_wr_t    WR,
    input wire logic [7:0]            RD_ADDR,
    input wire logic [7:0]            RD_DATA,
    input wire logic                  OC_FAULT,
    input wire logic [1:0]            SLEW_SELECT,
    input wire logic                  OVERCURRENT_AUTO_RESUME,
    input wire logic                  RIGHT_TO_BOTH_MIX,
    input wire logic                  LEFT_TO_BOTH_MIX,
    input wire amcr_pkg::amcr_setup_t SETUP,
    input wire logic                  GAIN_WRITE_LOCK,
    input wire logic                  OC_LATCHED,
    input wire logic                  ATTACK_STEP,
    input wire logic                  RELEASE_STEP
);
    wire mode_wr = WR.wr && WR.addr == 8'h02;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_mode_zero: assert property (RD_ADDR == 8'h02 |-> RD_DATA[7:6] == 2'h0)
        else $error("mode high bits set");
    a_timing_zero: assert property (RD_ADDR == 8'h03 |-> RD_DATA[7:6] == 2'h0)
        else $error("timing high bits set");
    a_slew_write: assert property (mode_wr |=> SLEW_SELECT == $past(WR.data[5:4]))
        else $error("slew not taken");
    a_mix_write: assert property (mode_wr |=>
        {RIGHT_TO_BOTH_MIX, LEFT_TO_BOTH_MIX} == $past(WR.data[1:0]))
        else $error("mix not taken");
    a_setup_write: assert property (WR.wr && WR.addr == 8'h04 |=> SETUP == $past(WR.data))
        else $error("setup not taken");
    a_lock_mirror: assert property (GAIN_WRITE_LOCK == SETUP.level_control_on)
        else $error("lock wrong");
    a_fault_latch: assert property (OC_FAULT && !OVERCURRENT_AUTO_RESUME |=> OC_LATCHED)
        else $error("fault not latched");
    a_fault_clear: assert property (WR.wr && WR.addr == 8'h07 && !OC_FAULT |=> !OC_LATCHED)
        else $error("fault not cleared");
    // Shortest attack step is ATTACK_BASE cycles, four in this bench
    a_attack_gap: assert property (ATTACK_STEP |=> !ATTACK_STEP [*3])
        else $error("attack steps too close");
    a_off_quiet: assert property (!SETUP.level_control_on &&
        !$past(SETUP.level_control_on) |-> !ATTACK_STEP && !RELEASE_STEP)
        else $error("step while off");
endmodule // amcr_regs_properties

bind amcr_regs amcr_regs_properties #(
    .ATTACK_BASE (ATTACK_BASE),
    .RELEASE_BASE(RELEASE_BASE)
) i_amcr_regs_properties (.*);

// ### tb/amcr_host.sv
`timescale 1ns/1ps
module amcr_host (
    input wire logic           CLK,
    output amcr_pkg::amcr_wr_t WR
);
    initial WR = '0;
    // One idle cycle between writes keeps each strobe a single cycle
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        WR <= {1'b1, a, d};
        @(negedge CLK);
        WR.wr <= 1'b0;
    endtask
endmodule // amcr_host

// ### tb/amcr_regs_tb.sv
`timescale 1ns/1ps
module amcr_regs_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic oc_fault = 1'b0;
    logic ot_fault = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data;
    logic [1:0] slew;
    logic ocr, otr, rmix, lmix, lock, ocl, otl, atk, rel;
    logic signed [7:0] half;
    amcr_pkg::amcr_wr_t wr;
    amcr_pkg::amcr_setup_t setup;
    int n_mismatch = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    amcr_host i_amcr_host (.CLK(clk), .WR(wr));
    amcr_regs #(.ATTACK_BASE(4), .RELEASE_BASE(8)) i_amcr_regs (
        .CLK(clk), .ARST_N(arst_n), .WR(wr), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .OC_FAULT(oc_fault), .OT_FAULT(ot_fault), .SLEW_SELECT(slew),
        .OVERCURRENT_AUTO_RESUME(ocr), .OVERTEMP_AUTO_RESUME(otr),
        .RIGHT_TO_BOTH_MIX(rmix), .LEFT_TO_BOTH_MIX(lmix), .SETUP(setup),
        .GAIN_WRITE_LOCK(lock), .OC_LATCHED(ocl), .OT_LATCHED(otl),
        .ATTACK_STEP(atk), .RELEASE_STEP(rel), .GAIN_STEP_HALF_DB(half));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd_addr = a;
        #1 chk(rd_data, exp);
    endtask
    task automatic gap(input bit use_rel, input int exp);
        int n;
        for (int k = 0; k < 2; k++)
        begin
            @(negedge clk);
            for (n = 1; n < 200 && (use_rel ? rel : atk) !== 1'b1; n++)
                @(negedge clk);
            if (n == 200)
            begin
                n_mismatch++;
                report_and_stop();
            end
        end
        chk(8'(n), 8'(exp));
    endtask
    task automatic t_reset();
        rd(8'h02, 8'h0c);
        rd(8'h03, 8'h2b);
        rd(8'h04, 8'h5b);
        rd(8'h05, 8'h00);
    endtask
    task automatic t_mode();
        i_amcr_host.put(8'h02, 8'hff);
        rd(8'h02, 8'h3f);
        chk({4'h0, ocr, otr, rmix, lmix}, 8'h0f);
        i_amcr_host.put(8'h03, 8'hff);
        rd(8'h03, 8'h3f);
        for (int c = 0; c < 4; c++)
        begin
            i_amcr_host.put(8'h02, 8'(c << 4));
            chk({6'h00, slew}, 8'(c));
        end
    endtask
    task automatic t_fault();
        @(negedge clk);
        oc_fault = 1'b1;
        ot_fault = 1'b1;
        @(negedge clk);
        oc_fault = 1'b0;
        ot_fault = 1'b0;
        chk({6'h00, ocl, otl}, 8'h03);
        i_amcr_host.put(8'h07, 8'h00);
        chk({6'h00, ocl, otl}, 8'h00);
    endtask
    task automatic t_steps();
        i_amcr_host.put(8'h03, 8'h10);
        i_amcr_host.put(8'h04, 8'h80);
        chk({7'h00, lock}, 8'h01);
        gap(1'b0, 4);
        gap(1'b1, 32);
        chk(half, 8'h01);
        i_amcr_host.put(8'h04, 8'h00);
        chk({7'h00, lock}, 8'h00);
    endtask
    task automatic t_rereset();
        i_amcr_host.put(8'h02, 8'h00);
        i_amcr_host.put(8'h04, 8'h80);
        arst_n = 1'b0;
        #1 chk({6'h00, atk, lock}, 8'h00);
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        rd(8'h02, 8'h0c);
        rd(8'h04, 8'h5b);
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_mode();
        t_fault();
        t_steps();
        t_rereset();
        report_and_stop();
    end
endmodule // amcr_regs_tb
